/* File: pkg/hol_pkg.sv */
// hardware option loader: shared constants and types
// assumes a 10 MHz system clock and byte wide option storage
package hol_pkg;

   // option storage: bytes at base, kept inverted so erased reads as off
   localparam int         OPT_BYTES = 3;
   localparam logic [7:0] NVM_BASE  = 8'h00;

   // decoded option word field positions
   localparam int B_LOCK     = 0;
   localparam int ISP_LO     = 1;  // 3 bit size code, 0 = no region
   localparam int B_BOOT_PWR = 4;
   localparam int B_BOOT_ANY = 5;
   localparam int B_BOD_UP   = 6;
   localparam int B_BOD_LO   = 7;
   localparam int B_LBOD_RST = 8;
   localparam int B_HBOD_RST = 9;
   localparam int B_WD_RST   = 10;
   localparam int B_WD_NS    = 11;
   localparam int B_WD_AUTO  = 12;
   localparam int B_WD_IDLE  = 13;
   localparam int PS_LO      = 14; // 3 bit prescaler
   localparam int B_WD_WP    = 17;
   localparam int IAP_LO     = 18; // 6 bit size in 512 byte units

   // register offsets
   localparam logic [3:0] A_WDOG  = 4'h0;
   localparam logic [3:0] A_INAPP_LOWER_BOUNDARY_REG = 4'h1;
   localparam logic [3:0] A_OPT   = 4'h2;
   localparam logic [3:0] A_BOOT  = 4'h3;
   localparam logic [3:0] A_ISPST = 4'h4;

   // watchdog control register fields
   localparam int W_PS_LO = 0;
   localparam int W_IDLE  = 3;
   localparam int W_NS    = 4;
   localparam int W_EN    = 5;
   localparam int W_RST   = 6;
   localparam int W_OVF   = 7;

   // flash map
   localparam logic [15:0] FLASH_TOP = 16'h8000; // one past 0x7fff
   localparam logic [15:0] ISP_STEP  = 16'h0200;
   localparam logic [15:0] APP_START = 16'h0000;
   localparam logic [7:0]  INAPP_LOWER_BOUNDARY_REG_RST = 8'h70;
   localparam logic [7:0]  DUMP_LOCK = 8'hff;

   // cpu reset hold time
   localparam int CLK_NS       = 100;
   localparam int RST_HOLD_NS  = 2000;
   localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [1:0] {HOL_S_LOAD, HOL_S_HOLD, HOL_S_RUN}
      hol_state_t;
   typedef enum logic [1:0] {HOL_C_POR, HOL_C_BOD, HOL_C_OTHER}
      hol_cause_t;

endpackage

/* File: tb/hol_nvm_model.sv */
// option storage model: the bytes an external programmer leaves behind
// assumes a read strobe is answered one cycle later, bytes kept inverted
`timescale 1ns/100ps

module hol_nvm_model (
   // clock
   input  wire logic        ref_clk,
   // storage port
   input  wire logic [7:0]  nvm_addr,
   input  wire logic        nvm_rd,
   output logic      [7:0]  nvm_rdata,
   // option word as programmed
   input  wire logic [23:0] opt_word
);
   logic [7:0] off;

   assign off = nvm_addr - hol_pkg::NVM_BASE;

   // erased cells read 0xff, which inverts to every option off
   // idle cycles toggle the bus so a late capture cannot pass by luck
   always @(posedge ref_clk) begin
      if (nvm_rd) begin
         if (off < 8'h03) begin
            nvm_rdata <= ~opt_word[off*8 +: 8];
         end else begin
            nvm_rdata <= 8'hff;
         end
      end else begin
         nvm_rdata <= ~nvm_rdata;
      end
   end
endmodule

/* File: tb/hol_top_tb_top.sv */
// self-checking bench for the option loader, random option words
// assumes hol_top and hol_nvm_model on one 10 MHz clock
`timescale 1ns/100ps

module hol_top_tb_top;
   localparam int HOLD = 8; // shortened cpu hold, outlasts bod sync delay
   // design inputs
   logic        ref_clk        = 1'b0;
   logic        sys_rst        = 1'b1;
   logic [3:0]  reg_addr       = 4'h0;
   logic [7:0]  reg_wdata      = 8'h00;
   logic        reg_wr         = 1'b0;
   logic        reg_rd         = 1'b0;
   logic        low_brownout_detector        = 1'b0;
   logic        selectable_brownout_detector = 1'b0;
   logic        wdog_overflow_flag = 1'b0;
   logic        ext_rst_req    = 1'b0;
   logic        prog_dump_rd   = 1'b0;
   logic [7:0]  prog_code_byte = 8'h00;
   logic [23:0] ow             = 24'h000000;
   // design outputs
   wire logic [7:0]  nvm_addr, nvm_rdata, reg_rdata, prog_dump_byte;
   wire logic [7:0]  iap_lower_boundary;
   wire logic [15:0] cpu_start_addr, isp_start_addr;
   wire logic        nvm_rd, prog_dump_vld, cpu_rst, isp_present;
   wire logic        opt_loaded, bod_hi_level_sel_upper;
   wire logic        bod_hi_level_sel_lower, wdog_en, wdog_reset_enable_bit;
   wire logic        wdog_nonstop_bit, wdog_idle_run_bit;
   wire logic [2:0]  wdog_prescale_bits;
   // bench state
   int          n_mismatch = 0;
   int          tests_run  = 0;
   integer      seed       = 32'h7c97;
   logic [6:0]  exp_wd;
   logic [7:0]  rv, rb;

   // clock
   always #50 ref_clk = ~ref_clk;

   hol_top #(.HOLD_CYC(HOLD)) uut (.ref_clk, .sys_rst, .nvm_addr, .nvm_rd,
      .nvm_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .low_brownout_detector, .selectable_brownout_detector,
      .wdog_overflow_flag, .ext_rst_req, .prog_dump_rd, .prog_code_byte,
      .prog_dump_byte, .prog_dump_vld, .cpu_rst, .cpu_start_addr,
      .isp_start_addr, .isp_present, .iap_lower_boundary, .opt_loaded,
      .bod_hi_level_sel_upper, .bod_hi_level_sel_lower, .wdog_en,
      .wdog_reset_enable_bit, .wdog_nonstop_bit, .wdog_idle_run_bit,
      .wdog_prescale_bits);

   hol_nvm_model nvm (.ref_clk, .nvm_addr, .nvm_rd, .nvm_rdata,
      .opt_word(ow));

   // expectations from the option word
   function automatic logic [15:0] isp_of(input logic [23:0] w);
      // an absent region still reports the decoded start of code zero
      return hol_pkg::FLASH_TOP -
         hol_pkg::ISP_STEP * ({13'h0, w[3:1]} + 16'h0001);
   endfunction

   function automatic logic [15:0] start_of(input logic [23:0] w,
                                            input logic pwr);
      if ((w[5] || (pwr && w[4])) && w[3:1] != 3'h0) return isp_of(w);
      return hol_pkg::APP_START;
   endfunction

   function automatic logic [7:0] iap_of(input logic [23:0] w);
      logic [15:0] t;
      t = (w[3:1] != 3'h0) ? isp_of(w) : hol_pkg::FLASH_TOP;
      return t[15:8] - {1'b0, w[23:18], 1'b0};
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // step just past the edge so its updates have landed
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask

   // strobes stay up between back-to-back calls; bus_idle drops them
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      tick();
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      reg_wr <= 1'b0;
      reg_addr <= a;
      reg_rd <= 1'b1;
      tick();
      d = reg_rdata;
   endtask

   task automatic bus_idle();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      tick();
   endtask

   task automatic wait_rst(input logic lvl);
      for (int n = 0; n < 40 && cpu_rst !== lvl; n++) tick();
      if (cpu_rst !== lvl) begin
         n_mismatch++;
         summarize();
      end
   endtask

   task automatic chk_map(input logic [23:0] w);
      chk(cpu_start_addr, start_of(w, 1'b1));
      chk(isp_start_addr, isp_of(w));
      chk(isp_present, w[3:1] != 3'h0);
      chk(iap_lower_boundary, iap_of(w));
      chk({bod_hi_level_sel_upper, bod_hi_level_sel_lower},
          {w[6], w[7]});
      chk({wdog_reset_enable_bit, wdog_en, wdog_nonstop_bit,
           wdog_idle_run_bit, wdog_prescale_bits}, exp_wd);
   endtask

   task automatic power_up(input logic [23:0] w);
      ow <= w;
      sys_rst <= 1'b1;
      exp_wd = {w[10], w[12], w[11], w[12] & w[13], w[12] ? w[16:14] : 3'h0};
      repeat (12) tick();
      chk(cpu_rst, 1'b1);
      sys_rst <= 1'b0;
      for (int n = 0; n < 40 && opt_loaded !== 1'b1; n++) tick();
      chk(opt_loaded, 1'b1);
      if (opt_loaded !== 1'b1) summarize();
      chk(cpu_rst, 1'b1);
      chk_map(w);
      wait_rst(1'b0);
      chk_map(w);
   endtask

   // raise one reset source and hold it until the cpu is seen in reset or 10 cycles pass
   task automatic fire(input int sel, input logic hit, input logic [15:0] st);
      ext_rst_req <= (sel == 0);
      low_brownout_detector <= (sel == 1);
      selectable_brownout_detector <= (sel == 2);
      wdog_overflow_flag <= (sel == 3);
      for (int n = 0; n < 10 && cpu_rst !== 1'b1; n++) tick();
      ext_rst_req <= 1'b0;
      low_brownout_detector <= 1'b0;
      selectable_brownout_detector <= 1'b0;
      wdog_overflow_flag <= 1'b0;
      chk(cpu_rst, hit);
      if (hit) chk(cpu_start_addr, st);
      wait_rst(1'b0);
      repeat (8) tick();
   endtask

   // erased and all-set corners first, then random option words
   initial begin
      logic [23:0] w;
      int          sel;
      logic        hit;
      logic [15:0] ia;
      for (int i = 0; i < 24; i++) begin
         w = (i == 0) ? 24'h000000 :
             (i == 1) ? 24'hffffff : 24'($random(seed));
         power_up(w);
         rv = 8'($random(seed));
         prog_code_byte <= rv;
         prog_dump_rd <= 1'b1;
         tick();
         prog_dump_rd <= 1'b0;
         chk(prog_dump_vld, 1'b1);
         chk(prog_dump_byte, w[0] ? hol_pkg::DUMP_LOCK : rv);
         // option view is read only, unmapped writes land nowhere
         rd(4'h2, rv);
         chk(rv, {w[0], w[3:1] != 3'h0, w[4], w[5], w[8], w[9],
                  w[17], w[12]});
         wr(4'h2, ~rv);
         wr(4'hf, 8'h5a);
         rd(4'h2, rb);
         chk(rb, rv);
         chk(isp_start_addr, isp_of(w));
         // boot status and loader start views after power-up
         rd(4'h3, rb);
         chk(rb, {6'h00, start_of(w, 1'b1) != hol_pkg::APP_START,
                  1'b1});
         ia = isp_of(w);
         rd(4'h4, rb);
         chk(rb, ia[15:8]);
         rv = 8'($random(seed));
         wr(4'h1, rv);
         rd(4'h1, rb);
         chk(rb, rv);
         chk(iap_lower_boundary, rv);
         // watchdog write: enable set-only, the rest frozen by protect
         rv = 8'($random(seed));
         wr(4'h0, rv);
         exp_wd[5] = exp_wd[5] | rv[5];
         if (!w[17]) {exp_wd[6], exp_wd[4:0]} = {rv[6], rv[4:0]};
         chk({wdog_reset_enable_bit, wdog_en, wdog_nonstop_bit,
              wdog_idle_run_bit, wdog_prescale_bits}, exp_wd);
         rd(4'h0, rb);
         chk(rb, {1'b0, exp_wd});
         bus_idle();
         chk(reg_rdata, 8'h00);
         sel = i % 4;
         hit = (sel == 0) || (sel == 1 && w[8]) || (sel == 2 && w[9]) ||
               (sel == 3 && exp_wd[6]);
         fire(sel, hit, (sel == 1 || sel == 2) ? hol_pkg::APP_START :
              start_of(w, 1'b0));
      end
      summarize();
   end
endmodule

/* File: verilog/hol_opt_reader.sv */
// option reader: fetches the option bytes after power-on reset
// assumes storage answers a read strobe with data one cycle later
`timescale 1ns/100ps

module hol_opt_reader #(
   parameter int NB = hol_pkg::OPT_BYTES
) (
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          sys_rst,
   // storage port
   output wire logic [7:0]    nvm_addr,
   output wire logic          nvm_rd,
   input  wire logic [7:0]    nvm_rdata,
   // decoded word
   output wire logic [NB*8-1:0] opt_word,
   output wire logic          opt_done
);

   localparam int IW = $clog2(NB + 1);

   typedef struct packed {
      logic [IW-1:0]  idx;
      logic           pend;
      logic           rd;
      logic           done;
      logic [7:0]     addr;
      logic [NB*8-1:0] word;
   } hol_rdr_st_t;

   hol_rdr_st_t q, n;

   // one read at a time; erased cells read all ones, stored inverted
   always_comb begin
      n = q;
      n.rd = 1'b0;
      // storage answers in the cycle after the strobe, not during it
      n.pend = q.rd;
      if (q.pend) begin
         n.word[q.idx*8 +: 8] = ~nvm_rdata;
         n.idx = q.idx + IW'(1);
         n.done = (q.idx == IW'(NB - 1));
      end else if (!q.done && !q.rd) begin
         n.rd = 1'b1;
         n.addr = hol_pkg::NVM_BASE + 8'(q.idx);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign nvm_addr = q.addr;
   assign nvm_rd   = q.rd;
   assign opt_word = q.word;
   assign opt_done = q.done;

endmodule

/* File: verilog/hol_sync3.sv */
// three stage synchroniser with agreement filter
// assumes input is asynchronous to ref_clk
`timescale 1ns/100ps

module hol_sync3 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   // async in, filtered level out
   input  wire logic [W-1:0] async_in,
   output wire logic [W-1:0] level_out
);

   typedef struct packed {
      logic [W-1:0] f1;
      logic [W-1:0] f2;
      logic [W-1:0] f3;
      logic [W-1:0] lvl;
   } hol_sync_st_t;

   hol_sync_st_t q, n;

   // f1 feeds only f2; level moves when f2 and f3 agree
   always_comb begin
      n = q;
      n.f1 = async_in;
      n.f2 = q.f1;
      n.f3 = q.f2;
      for (int i = 0; i < W; i++) begin
         if (q.f2[i] == q.f3[i]) begin
            n.lvl[i] = q.f3[i];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign level_out = q.lvl;

endmodule

/* File: verilog/hol_top.sv */
// hardware option loader: applies option bits to boot, brown-out
// and watchdog behaviour; holds the cpu in reset until applied
// assumes one clock, synchronous power-on reset, same-clock strobes

`timescale 1ns/100ps

module hol_top #(
   parameter int HOLD_CYC = hol_pkg::RST_HOLD_CYC
) (
   // clock and power-on reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // option storage
   output wire logic [7:0]  nvm_addr,
   output wire logic        nvm_rd,
   input  wire logic [7:0]  nvm_rdata,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output wire logic [7:0]  reg_rdata,
   // reset sources
   input  wire logic        low_brownout_detector,
   input  wire logic        selectable_brownout_detector,
   input  wire logic        wdog_overflow_flag,
   input  wire logic        ext_rst_req,
   // programmer code dump
   input  wire logic        prog_dump_rd,
   input  wire logic [7:0]  prog_code_byte,
   output wire logic [7:0]  prog_dump_byte,
   output wire logic        prog_dump_vld,
   // cpu and flash map
   output wire logic        cpu_rst,
   output wire logic [15:0] cpu_start_addr,
   output wire logic [15:0] isp_start_addr,
   output wire logic        isp_present,
   output wire logic [7:0]  iap_lower_boundary,
   output wire logic        opt_loaded,
   // brown-out level select
   output wire logic        bod_hi_level_sel_upper,
   output wire logic        bod_hi_level_sel_lower,
   // watchdog control
   output wire logic        wdog_en,
   output wire logic        wdog_reset_enable_bit,
   output wire logic        wdog_nonstop_bit,
   output wire logic        wdog_idle_run_bit,
   output wire logic [2:0]  wdog_prescale_bits
);

   localparam int CW = $clog2(HOLD_CYC + 1);
   localparam int OW = hol_pkg::OPT_BYTES * 8;

   typedef struct packed {
      hol_pkg::hol_state_t st;
      hol_pkg::hol_cause_t cause;
      logic [CW-1:0]       cnt;
      logic [OW-1:0]       opt;
      logic                loaded;
      logic                cpu_rst;
      logic [15:0]         start;
      logic [15:0]         isp;
      logic                isp_on;
      logic [6:0]          wdc;
      logic [7:0]          inapp_lower_boundary_reg;
      logic [7:0]          rdata;
      logic [7:0]          dump;
      logic                dump_vld;
   } hol_top_st_t;

   localparam hol_top_st_t RST_VAL = '{
      st:    hol_pkg::HOL_S_LOAD,
      cause: hol_pkg::HOL_C_POR,
      cpu_rst: 1'b1,
      inapp_lower_boundary_reg: hol_pkg::INAPP_LOWER_BOUNDARY_REG_RST,
      dump:  hol_pkg::DUMP_LOCK,
      default: '0
   };

   hol_top_st_t q, n;

   logic [OW-1:0] rdr_word;
   logic          rdr_done;
   logic          bod_lo_lvl;
   logic          bod_hi_lvl;

   // option fetch after power-on reset
   hol_opt_reader #(
      .NB (hol_pkg::OPT_BYTES)
   ) u_reader (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .nvm_addr  (nvm_addr),
      .nvm_rd    (nvm_rd),
      .nvm_rdata (nvm_rdata),
      .opt_word  (rdr_word),
      .opt_done  (rdr_done)
   );

   // detector outputs are analog and asynchronous
   hol_sync3 #(.W(1)) u_sync_lo (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .async_in  (low_brownout_detector),
      .level_out (bod_lo_lvl)
   );

   hol_sync3 #(.W(1)) u_sync_hi (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .async_in  (selectable_brownout_detector),
      .level_out (bod_hi_lvl)
   );

   // decode of the freshly read word; brown-out events from the latched options, watchdog event from the control register
   logic [2:0]  isp_code;
   logic [15:0] isp_dec;
   logic [15:0] iap_base;
   logic        lbod_ev;
   logic        hbod_ev;
   logic        wd_ev;

   always_comb begin
      isp_code = rdr_word[hol_pkg::ISP_LO +: 3];
      // region always ends at 0x7fff; only the start moves
      isp_dec  = hol_pkg::FLASH_TOP
               - (16'(isp_code) + 16'h0001) * hol_pkg::ISP_STEP;
      iap_base = (isp_code != 3'h0) ? isp_dec : hol_pkg::FLASH_TOP;
      lbod_ev  = bod_lo_lvl && q.opt[hol_pkg::B_LBOD_RST];
      hbod_ev  = bod_hi_lvl && q.opt[hol_pkg::B_HBOD_RST];
      wd_ev    = wdog_overflow_flag && q.wdc[hol_pkg::W_RST];
   end

   // sequencer, watchdog control, registers and dump path
   always_comb begin
      n = q;
      n.rdata = 8'h00;
      n.dump_vld = prog_dump_rd;
      unique case (q.st)
         hol_pkg::HOL_S_LOAD: begin
            n.cpu_rst = 1'b1;
            if (rdr_done) begin
               // word is latched once here and never rewritten
               n.opt    = rdr_word;
               n.loaded = 1'b1;
               n.isp    = isp_dec;
               n.isp_on = (isp_code != 3'h0);
               n.inapp_lower_boundary_reg  = iap_base[15:8]
                        - {1'b0, rdr_word[hol_pkg::IAP_LO +: 6], 1'b0};
               n.wdc = '0;
               n.wdc[hol_pkg::W_RST] = rdr_word[hol_pkg::B_WD_RST];
               n.wdc[hol_pkg::W_NS]  = rdr_word[hol_pkg::B_WD_NS];
               if (rdr_word[hol_pkg::B_WD_AUTO]) begin
                  n.wdc[hol_pkg::W_EN]   = 1'b1;
                  n.wdc[hol_pkg::W_IDLE] = rdr_word[hol_pkg::B_WD_IDLE];
                  n.wdc[hol_pkg::W_PS_LO +: 3] =
                     rdr_word[hol_pkg::PS_LO +: 3];
               end
               // power-up: either boot option selects the loader when a region is present
               n.start = ((isp_code != 3'h0)
                         && (rdr_word[hol_pkg::B_BOOT_PWR]
                         || rdr_word[hol_pkg::B_BOOT_ANY]))
                       ? isp_dec : hol_pkg::APP_START;
               n.cause = hol_pkg::HOL_C_POR;
               n.cnt   = CW'(HOLD_CYC);
               n.st    = hol_pkg::HOL_S_HOLD;
            end
         end
         hol_pkg::HOL_S_HOLD: begin
            if (q.cnt == '0) begin
               n.cpu_rst = 1'b0;
               n.st = hol_pkg::HOL_S_RUN;
            end else begin
               n.cnt = q.cnt - CW'(1);
            end
         end
         hol_pkg::HOL_S_RUN: begin
            if (lbod_ev || hbod_ev) begin
               // brown-out always restarts the application
               n.start = hol_pkg::APP_START;
               n.cause = hol_pkg::HOL_C_BOD;
               n.cpu_rst = 1'b1;
               n.cnt = CW'(HOLD_CYC);
               n.st = hol_pkg::HOL_S_HOLD;
            end else if (wd_ev || ext_rst_req) begin
               n.start = (q.isp_on && q.opt[hol_pkg::B_BOOT_ANY])
                       ? q.isp : hol_pkg::APP_START;
               n.cause = hol_pkg::HOL_C_OTHER;
               n.cpu_rst = 1'b1;
               n.cnt = CW'(HOLD_CYC);
               n.st = hol_pkg::HOL_S_HOLD;
            end
         end
         default: n.st = hol_pkg::HOL_S_LOAD; // illegal code, reload
      endcase

      // writes wait for options, else protection would be unknown
      if (reg_wr && q.loaded) begin
         case (reg_addr)
            hol_pkg::A_WDOG: begin
               // enable is set-only, it cannot be switched off
               n.wdc[hol_pkg::W_EN] = q.wdc[hol_pkg::W_EN]
                                    | reg_wdata[hol_pkg::W_EN];
               if (!q.opt[hol_pkg::B_WD_WP]) begin
                  n.wdc[hol_pkg::W_RST]  = reg_wdata[hol_pkg::W_RST];
                  n.wdc[hol_pkg::W_NS]   = reg_wdata[hol_pkg::W_NS];
                  n.wdc[hol_pkg::W_IDLE] = reg_wdata[hol_pkg::W_IDLE];
                  n.wdc[hol_pkg::W_PS_LO +: 3] =
                     reg_wdata[hol_pkg::W_PS_LO +: 3];
               end
            end
            hol_pkg::A_INAPP_LOWER_BOUNDARY_REG: n.inapp_lower_boundary_reg = reg_wdata;
            // option views are read only
            default: n.inapp_lower_boundary_reg = q.inapp_lower_boundary_reg;
         endcase
      end

      // read data stand one cycle, zero otherwise
      if (reg_rd) begin
         case (reg_addr)
            hol_pkg::A_WDOG:  n.rdata = {wdog_overflow_flag, q.wdc};
            hol_pkg::A_INAPP_LOWER_BOUNDARY_REG: n.rdata = q.inapp_lower_boundary_reg;
            hol_pkg::A_OPT:   n.rdata = {q.opt[hol_pkg::B_LOCK],
                                         q.isp_on,
                                         q.opt[hol_pkg::B_BOOT_PWR],
                                         q.opt[hol_pkg::B_BOOT_ANY],
                                         q.opt[hol_pkg::B_LBOD_RST],
                                         q.opt[hol_pkg::B_HBOD_RST],
                                         q.opt[hol_pkg::B_WD_WP],
                                         q.opt[hol_pkg::B_WD_AUTO]};
            hol_pkg::A_BOOT:  n.rdata = {4'h0, 2'(q.cause),
                                         q.start != hol_pkg::APP_START,
                                         q.loaded};
            hol_pkg::A_ISPST: n.rdata = q.isp[15:8];
            default:          n.rdata = 8'h00;
         endcase
      end

      // unknown lock state before load is treated as locked
      if (prog_dump_rd) begin
         n.dump = (!q.loaded || q.opt[hol_pkg::B_LOCK])
                ? hol_pkg::DUMP_LOCK : prog_code_byte;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         q <= RST_VAL;
      end else begin
         q <= n;
      end
   end

   // outputs straight from state flops
   assign reg_rdata              = q.rdata;
   assign prog_dump_byte         = q.dump;
   assign prog_dump_vld          = q.dump_vld;
   assign cpu_rst                = q.cpu_rst;
   assign cpu_start_addr         = q.start;
   assign isp_start_addr         = q.isp;
   assign isp_present            = q.isp_on;
   assign iap_lower_boundary     = q.inapp_lower_boundary_reg;
   assign opt_loaded             = q.loaded;
   assign bod_hi_level_sel_upper = q.opt[hol_pkg::B_BOD_UP];
   assign bod_hi_level_sel_lower = q.opt[hol_pkg::B_BOD_LO];
   assign wdog_en                = q.wdc[hol_pkg::W_EN];
   assign wdog_reset_enable_bit  = q.wdc[hol_pkg::W_RST];
   assign wdog_nonstop_bit       = q.wdc[hol_pkg::W_NS];
   assign wdog_idle_run_bit      = q.wdc[hol_pkg::W_IDLE];
   assign wdog_prescale_bits     = q.wdc[hol_pkg::W_PS_LO +: 3];

   // checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   chk_dump_locked: assert property (
      prog_dump_rd && q.loaded && q.opt[hol_pkg::B_LOCK]
      |=> prog_dump_vld && prog_dump_byte == 8'hff)
      else $error("locked dump leaked code");

   chk_hold_until_load: assert property (
      !q.loaded |-> cpu_rst)
      else $error("cpu released before options loaded");

   chk_opt_frozen: assert property (
      q.loaded && $past(q.loaded) |-> $stable(q.opt))
      else $error("option word changed at run time");

   chk_wp_fields: assert property (
      reg_wr && q.loaded && q.opt[hol_pkg::B_WD_WP]
      |=> $stable(q.wdc[6] ) && $stable(q.wdc[4:0]))
      else $error("protected watchdog field written");

   chk_isp_window: assert property (
      isp_present |-> isp_start_addr >= 16'h7000
                   && isp_start_addr <= 16'h7c00
                   && isp_start_addr[8:0] == 9'h000)
      else $error("loader start out of range");

   chk_bod_app_start: assert property (
      q.st == hol_pkg::HOL_S_RUN && bod_lo_lvl
      && q.opt[hol_pkg::B_LBOD_RST]
      |=> cpu_rst && cpu_start_addr == 16'h0000)
      else $error("low brown-out did not restart application");

   chk_hbod_off: assert property (
      q.st == hol_pkg::HOL_S_RUN && !bod_lo_lvl && !wd_ev
      && !ext_rst_req && !q.opt[hol_pkg::B_HBOD_RST]
      |=> !cpu_rst)
      else $error("disabled brown-out caused a reset");

   chk_wdog_reset: assert property (
      q.st == hol_pkg::HOL_S_RUN && !bod_lo_lvl && !bod_hi_lvl
      && wdog_overflow_flag && wdog_reset_enable_bit
      |=> cpu_rst ##1 cpu_rst)
      else $error("watchdog overflow did not reset");

   chk_auto_load: assert property (
      $rose(q.loaded) && q.opt[hol_pkg::B_WD_AUTO]
      |-> wdog_en && wdog_nonstop_bit == q.opt[hol_pkg::B_WD_NS]
          && wdog_prescale_bits == q.opt[hol_pkg::PS_LO +: 3])
      else $error("auto enable did not load watchdog");

   chk_por_boot: assert property (
      $rose(q.loaded) && isp_present && q.opt[hol_pkg::B_BOOT_PWR]
      |-> cpu_start_addr == isp_start_addr)
      else $error("power-up did not select loader");

   chk_inapp_lower_boundary_reg_write: assert property (
      reg_wr && q.loaded && reg_addr == hol_pkg::A_INAPP_LOWER_BOUNDARY_REG
      |=> iap_lower_boundary == $past(reg_wdata))
      else $error("boundary write lost");

   cov_loader_boot: cover property (
      $fell(cpu_rst) && cpu_start_addr != 16'h0000);
   cov_bod_reset: cover property (
      q.cause == hol_pkg::HOL_C_BOD && cpu_rst);
   cov_wdog_reset: cover property (
      q.cause == hol_pkg::HOL_C_OTHER && $fell(cpu_rst));

endmodule
